/* File: include/hpa_map.vh */
// Purpose: register indices, field positions and reset values of the
//          headphone amplifier mode control block
// Assumes: eight-bit registers reached by index over the two-wire port
// Notes:   definitions only
`ifndef HPA_MAP_VH
`define HPA_MAP_VH

// ****************************************************************
// register indices
// ****************************************************************
`define HPA_REG_CTRL 8'h01
`define HPA_REG_VOL 8'h02
`define HPA_REG_HIZ 8'h03
`define HPA_REG_VER 8'h04
`define HPA_REG_TEST5 8'h05
`define HPA_REG_TEST6 8'h06
`define HPA_REG_TEST7 8'h07
`define HPA_REG_TEST8 8'h08

// ****************************************************************
// field positions
// ****************************************************************
`define HPA_BIT_EN_L 7
`define HPA_BIT_EN_R 6
`define HPA_BIT_MODE_HI 5
`define HPA_BIT_MODE_LO 4
`define HPA_BIT_THERM 1
`define HPA_BIT_SLEEP 0
`define HPA_BIT_MUTE_L 7
`define HPA_BIT_MUTE_R 6
`define HPA_BIT_VOL_HI 5
`define HPA_BIT_FLT_L 1
`define HPA_BIT_FLT_R 0

// ****************************************************************
// output modes
// ****************************************************************
`define HPA_MODE_STEREO 2'h0
`define HPA_MODE_MONO 2'h1
`define HPA_MODE_BRIDGE 2'h2
`define HPA_MODE_RSVD 2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define HPA_RST_EN 2'h0
`define HPA_RST_MODE 2'h0
`define HPA_RST_SLEEP 1'h0
`define HPA_RST_MUTE 2'h3
`define HPA_RST_VOL 6'h00
`define HPA_RST_HIZ 2'h0

// ****************************************************************
// gain coding, tenths of a dB, two's complement
// ****************************************************************
`define HPA_MUTE_DB10 11'h418
`define HPA_VOL_FIRST_POS 6'h35

`endif

/* File: logic/hpa_ctrl.v */
// Purpose: two-wire register slave and mode control of a stereo
//          headphone amplifier
// Assumes: scl and sda sampled synchronously to core_clk, which runs
//          well above the bus bit rate
// Notes:   sda is open drain; only a low is ever driven
`timescale 1ns/10ps
`include "hpa_map.vh"
module hpa_ctrl #(
  parameter [6:0] DEV_ADDR = 7'h60,
  parameter [3:0] VERSION = 4'h0,
  parameter [7:0] TEST_FILL = 8'h00
)(
  input wire core_clk,
  input wire rstn,
  input wire hard_power_down_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire thermal_fault,
  output reg charge_pump_on,
  output reg left_amp_drive,
  output reg right_amp_drive,
  output reg left_output_pin_float,
  output reg right_output_pin_float,
  output reg stereo_drive,
  output reg mono_drive,
  output reg bridge_drive,
  output reg [10:0] left_gain,
  output reg [10:0] right_gain
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_DEV = 3'h1;
localparam [2:0] ST_REG = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_ACK = 3'h4;
localparam [2:0] ST_RD = 3'h5;
localparam [2:0] ST_MACK = 3'h6;

// register bank
reg left_amp_on;
reg right_amp_on;
reg [1:0] mode;
reg thermal;
reg soft_power_down_bit;
reg mute_l;
reg mute_r;
reg [5:0] vol;
reg left_out_float;
reg right_out_float;
reg [7:0] rdata;
// bus slave
reg scl_q;
reg sda_q;
reg [2:0] st;
reg [2:0] ret;
reg [3:0] cnt;
reg [7:0] shifter;
reg [7:0] ptr;
reg is_read;
reg sda_hold;
reg wr_stb;
reg [7:0] wr_idx;
reg [7:0] wr_data;
reg rd_stb;
reg [7:0] rd_idx;
wire [10:0] rom_gain;
wire start_seen;
wire stop_seen;
wire scl_rise;
wire scl_fall;
wire load_now;
wire active;
wire both_on;

// ****************************************************************
// bus pin handling
// ****************************************************************
assign sda_out = 1'b0;
assign sda_oe_n = ~sda_hold;
assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
assign scl_rise = scl_in & ~scl_q;
assign scl_fall = ~scl_in & scl_q;
// read byte is loaded after address ack or after master ack
assign load_now = scl_fall & ((st == ST_ACK & ret == ST_DEV & is_read)
  | (st == ST_MACK & cnt == 4'h9));

// read data mux
always @*
begin
  case (ptr)
    `HPA_REG_CTRL: rdata = {left_amp_on, right_amp_on, mode, 2'b00,
      thermal, soft_power_down_bit};
    `HPA_REG_VOL: rdata = {mute_l, mute_r, vol};
    `HPA_REG_HIZ: rdata = {6'h00, left_out_float, right_out_float};
    `HPA_REG_VER: rdata = {4'h0, VERSION};
    `HPA_REG_TEST5: rdata = TEST_FILL;
    `HPA_REG_TEST6: rdata = TEST_FILL;
    `HPA_REG_TEST7: rdata = TEST_FILL;
    `HPA_REG_TEST8: rdata = TEST_FILL;
    default: rdata = 8'h00;
  endcase
end

// ****************************************************************
// two-wire slave
// ****************************************************************
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    scl_q <= 1'b1;
    sda_q <= 1'b1;
    st <= ST_IDLE;
    ret <= ST_IDLE;
    cnt <= 4'h0;
    shifter <= 8'h00;
    ptr <= 8'h00;
    is_read <= 1'b0;
    sda_hold <= 1'b0;
    wr_stb <= 1'b0;
    wr_idx <= 8'h00;
    wr_data <= 8'h00;
    rd_stb <= 1'b0;
    rd_idx <= 8'h00;
  end
  else
  begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    if (!hard_power_down_n)
    begin
      // bus ignored while powered down
      st <= ST_IDLE;
      sda_hold <= 1'b0;
      ptr <= 8'h00;
    end
    else if (start_seen)
    begin
      st <= ST_DEV;
      cnt <= 4'h0;
      sda_hold <= 1'b0;
    end
    else if (stop_seen)
    begin
      st <= ST_IDLE;
      sda_hold <= 1'b0;
    end
    else if (load_now)
    begin
      // drive first bit of the read byte
      st <= ST_RD;
      shifter <= {rdata[6:0], 1'b0};
      sda_hold <= ~rdata[7];
      cnt <= 4'h1;
      rd_stb <= 1'b1;
      rd_idx <= ptr;
    end
    else
    begin
      case (st)
        ST_DEV, ST_REG, ST_WR:
        begin
          if (scl_rise && cnt < 4'h8)
          begin
            shifter <= {shifter[6:0], sda_in};
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            if (st == ST_DEV && shifter[7:1] != DEV_ADDR)
              st <= ST_IDLE;
            else
            begin
              ret <= st;
              st <= ST_ACK;
              sda_hold <= 1'b1;
              if (st == ST_DEV)
                is_read <= shifter[0];
              if (st == ST_REG)
                ptr <= shifter;
              if (st == ST_WR)
                wr_data <= shifter;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            sda_hold <= 1'b0;
            cnt <= 4'h0;
            if (ret == ST_DEV)
              st <= ST_REG;
            else
              st <= ST_WR;
            if (ret == ST_WR)
            begin
              // commit only after the ack clock ends
              wr_stb <= 1'b1;
              wr_idx <= ptr;
              ptr <= ptr + 8'h01;
            end
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (cnt == 4'h8)
            begin
              sda_hold <= 1'b0;
              st <= ST_MACK;
              ptr <= ptr + 8'h01;
            end
            else
            begin
              sda_hold <= ~shifter[7];
              shifter <= {shifter[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          // master nack ends the read
          if (scl_rise && sda_in)
            st <= ST_IDLE;
          else if (scl_rise)
            cnt <= 4'h9;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
end

// ****************************************************************
// register bank
// ****************************************************************
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    {left_amp_on, right_amp_on} <= `HPA_RST_EN;
    mode <= `HPA_RST_MODE;
    soft_power_down_bit <= `HPA_RST_SLEEP;
    thermal <= 1'b0;
    {mute_l, mute_r} <= `HPA_RST_MUTE;
    vol <= `HPA_RST_VOL;
    {left_out_float, right_out_float} <= `HPA_RST_HIZ;
  end
  else if (!hard_power_down_n)
  begin
    // contents lost while the pin is low
    {left_amp_on, right_amp_on} <= `HPA_RST_EN;
    mode <= `HPA_RST_MODE;
    soft_power_down_bit <= `HPA_RST_SLEEP;
    thermal <= 1'b0;
    {mute_l, mute_r} <= `HPA_RST_MUTE;
    vol <= `HPA_RST_VOL;
    {left_out_float, right_out_float} <= `HPA_RST_HIZ;
  end
  else
  begin
    // whole-byte writes; reserved bits dropped
    if (wr_stb && wr_idx == `HPA_REG_CTRL)
    begin
      soft_power_down_bit <= wr_data[`HPA_BIT_SLEEP];
      mode <= wr_data[`HPA_BIT_MODE_HI:`HPA_BIT_MODE_LO];
      left_amp_on <= wr_data[`HPA_BIT_EN_L] &
        ~wr_data[`HPA_BIT_SLEEP];
      right_amp_on <= wr_data[`HPA_BIT_EN_R] &
        ~wr_data[`HPA_BIT_SLEEP];
    end
    else if (soft_power_down_bit)
    begin
      left_amp_on <= 1'b0;
      right_amp_on <= 1'b0;
    end
    if (wr_stb && wr_idx == `HPA_REG_VOL)
    begin
      mute_l <= wr_data[`HPA_BIT_MUTE_L];
      mute_r <= wr_data[`HPA_BIT_MUTE_R];
      vol <= wr_data[`HPA_BIT_VOL_HI:0];
    end
    if (wr_stb && wr_idx == `HPA_REG_HIZ)
    begin
      left_out_float <= wr_data[`HPA_BIT_FLT_L];
      right_out_float <= wr_data[`HPA_BIT_FLT_R];
    end
    // clear on read, a new fault wins
    if (rd_stb && rd_idx == `HPA_REG_CTRL)
      thermal <= 1'b0;
    if (thermal_fault)
      thermal <= 1'b1;
  end
end

// ****************************************************************
// effective drive and gain outputs
// ****************************************************************
assign active = hard_power_down_n & ~soft_power_down_bit;
assign both_on = left_amp_on & right_amp_on;

hpa_gain_rom u_gain (
  .core_clk(core_clk),
  .rstn(rstn),
  .vol(vol),
  .gain(rom_gain)
);

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    charge_pump_on <= 1'b0;
    left_amp_drive <= 1'b0;
    right_amp_drive <= 1'b0;
    left_output_pin_float <= 1'b0;
    right_output_pin_float <= 1'b0;
    stereo_drive <= 1'b0;
    mono_drive <= 1'b0;
    bridge_drive <= 1'b0;
    left_gain <= `HPA_MUTE_DB10;
    right_gain <= `HPA_MUTE_DB10;
  end
  else
  begin
    // pump follows sleep and pin only
    charge_pump_on <= active;
    left_amp_drive <= active & left_amp_on &
      (mode != `HPA_MODE_RSVD);
    right_amp_drive <= active & right_amp_on &
      (mode != `HPA_MODE_RSVD);
    left_output_pin_float <= hard_power_down_n &
      left_out_float;
    right_output_pin_float <= hard_power_down_n & right_out_float;
    stereo_drive <= active & both_on &
      (mode == `HPA_MODE_STEREO);
    mono_drive <= active & both_on &
      (mode == `HPA_MODE_MONO);
    bridge_drive <= active & both_on &
      (mode == `HPA_MODE_BRIDGE);
    // mute overrides the table
    if (!hard_power_down_n || mute_l)
      left_gain <= `HPA_MUTE_DB10;
    else
      left_gain <= rom_gain;
    if (!hard_power_down_n || mute_r)
      right_gain <= `HPA_MUTE_DB10;
    else
      right_gain <= rom_gain;
  end
end

endmodule

/* File: logic/hpa_gain_rom.v */
// Purpose: audio taper lookup, volume code to gain in tenths of a dB
// Assumes: one clock, gain appears one edge after the code
// Notes:   table holds magnitudes; codes below the first positive
//          step are negated
`timescale 1ns/10ps
`include "hpa_map.vh"
module hpa_gain_rom (
  input wire core_clk,
  input wire rstn,
  input wire [5:0] vol,
  output reg [10:0] gain
);

reg [9:0] mag;

// ****************************************************************
// magnitude table
// ****************************************************************
always @*
begin
  case (vol)
    6'h00: mag = 10'h253;
    6'h01: mag = 10'h217;
    6'h02: mag = 10'h1F4;
    6'h03: mag = 10'h1DB;
    6'h04: mag = 10'h1C7;
    6'h05: mag = 10'h1B7;
    6'h06: mag = 10'h19E;
    6'h07: mag = 10'h18B;
    6'h08: mag = 10'h16D;
    6'h09: mag = 10'h161;
    6'h0A: mag = 10'h14D;
    6'h0B: mag = 10'h13D;
    6'h0C: mag = 10'h130;
    6'h0D: mag = 10'h11E;
    6'h0E: mag = 10'h10F;
    6'h0F: mag = 10'h107;
    6'h10: mag = 10'h0F7;
    6'h11: mag = 10'h0ED;
    6'h12: mag = 10'h0E1;
    6'h13: mag = 10'h0D9;
    6'h14: mag = 10'h0CD;
    6'h15: mag = 10'h0C4;
    6'h16: mag = 10'h0BC;
    6'h17: mag = 10'h0B2;
    6'h18: mag = 10'h0AA;
    6'h19: mag = 10'h0A2;
    6'h1A: mag = 10'h098;
    6'h1B: mag = 10'h091;
    6'h1C: mag = 10'h089;
    6'h1D: mag = 10'h082;
    6'h1E: mag = 10'h07B;
    6'h1F: mag = 10'h074;
    6'h20: mag = 10'h06D;
    6'h21: mag = 10'h067;
    6'h22: mag = 10'h061;
    6'h23: mag = 10'h05A;
    6'h24: mag = 10'h055;
    6'h25: mag = 10'h04E;
    6'h26: mag = 10'h048;
    6'h27: mag = 10'h043;
    6'h28: mag = 10'h03D;
    6'h29: mag = 10'h038;
    6'h2A: mag = 10'h033;
    6'h2B: mag = 10'h02D;
    6'h2C: mag = 10'h029;
    6'h2D: mag = 10'h023;
    6'h2E: mag = 10'h01F;
    6'h2F: mag = 10'h01A;
    6'h30: mag = 10'h015;
    6'h31: mag = 10'h011;
    6'h32: mag = 10'h00C;
    6'h33: mag = 10'h008;
    6'h34: mag = 10'h003;
    6'h35: mag = 10'h001;
    6'h36: mag = 10'h005;
    6'h37: mag = 10'h009;
    6'h38: mag = 10'h00E;
    6'h39: mag = 10'h011;
    6'h3A: mag = 10'h015;
    6'h3B: mag = 10'h019;
    6'h3C: mag = 10'h01D;
    6'h3D: mag = 10'h021;
    6'h3E: mag = 10'h024;
    6'h3F: mag = 10'h028;
    default: mag = 10'h253;
  endcase
end

// ****************************************************************
// signed, registered gain
// ****************************************************************
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    gain <= 11'h000;
  else if (vol < `HPA_VOL_FIRST_POS)
    gain <= 11'h000 - {1'b0, mag};
  else
    gain <= {1'b0, mag};
end

endmodule

/* File: tb/hpa_assertions.sv */
// Purpose: pin-level checker of the amplifier mode control
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module hpa_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hard_power_down_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic thermal_fault,
  input wire logic charge_pump_on,
  input wire logic left_amp_drive,
  input wire logic right_amp_drive,
  input wire logic left_output_pin_float,
  input wire logic right_output_pin_float,
  input wire logic stereo_drive,
  input wire logic mono_drive,
  input wire logic bridge_drive,
  input wire logic [10:0] left_gain,
  input wire logic [10:0] right_gain
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // pin low keeps pump, amps and modes off
  property p_hard_off;
    !hard_power_down_n [*3] |-> !charge_pump_on && !left_amp_drive &&
      !right_amp_drive && !stereo_drive && !mono_drive && !bridge_drive;
  endproperty
  a_hard_off: assert property (p_hard_off)
    else $error("output active in hard power-down");
  property p_hard_mute;
    !hard_power_down_n [*4] |->
      left_gain == 11'h418 && right_gain == 11'h418;
  endproperty
  a_hard_mute: assert property (p_hard_mute)
    else $error("gain not muted in hard power-down");
  property p_hard_bus;
    !hard_power_down_n [*3] |-> sda_oe_n;
  endproperty
  a_hard_bus: assert property (p_hard_bus)
    else $error("bus answered in hard power-down");
  property p_float_pin;
    left_output_pin_float || right_output_pin_float |->
      $past(hard_power_down_n);
  endproperty
  a_float_pin: assert property (p_float_pin)
    else $error("float while pin low");
  property p_mode_drv;
    stereo_drive || mono_drive || bridge_drive |->
      left_amp_drive && right_amp_drive;
  endproperty
  a_mode_drv: assert property (p_mode_drv)
    else $error("mode without both amps");
  property p_mode_one;
    $onehot0({stereo_drive, mono_drive, bridge_drive});
  endproperty
  a_mode_one: assert property (p_mode_one)
    else $error("two modes at once");
  property p_drv_pump;
    left_amp_drive || right_amp_drive |-> charge_pump_on;
  endproperty
  a_drv_pump: assert property (p_drv_pump)
    else $error("amp drives without pump");
  property p_gain_rng;
    (left_gain == 11'h418 || ($signed(left_gain) >= -595 &&
      $signed(left_gain) <= 40)) && (right_gain == 11'h418 ||
      ($signed(right_gain) >= -595 && $signed(right_gain) <= 40));
  endproperty
  a_gain_rng: assert property (p_gain_rng)
    else $error("gain outside table");
  property p_pump_rise;
    $rose(charge_pump_on) |-> $past(hard_power_down_n);
  endproperty
  a_pump_rise: assert property (p_pump_rise)
    else $error("pump started with pin low");
  c_stereo: cover property (stereo_drive);
  c_bridge: cover property (bridge_drive);
  c_ack: cover property (!sda_oe_n);
  c_sleep: cover property ($fell(charge_pump_on));
endmodule

bind hpa_ctrl hpa_assertions u_chk (
  .core_clk(core_clk), .rstn(rstn),
  .hard_power_down_n(hard_power_down_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .thermal_fault(thermal_fault),
  .charge_pump_on(charge_pump_on), .left_amp_drive(left_amp_drive),
  .right_amp_drive(right_amp_drive),
  .left_output_pin_float(left_output_pin_float),
  .right_output_pin_float(right_output_pin_float),
  .stereo_drive(stereo_drive), .mono_drive(mono_drive),
  .bridge_drive(bridge_drive), .left_gain(left_gain),
  .right_gain(right_gain)
);

/* File: tb/hpa_host.sv */
// Purpose: two-wire bus master model driving the block
// Assumes: changes only at falling core edges
// Notes: sda_rel high lets the pull-up win
`timescale 1ns/10ps
module hpa_host (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // set both lines, then hold a quarter bit
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_rel = d;
    repeat (4) @(negedge core_clk);
  endtask
  // start, also usable as repeated start
  task automatic start();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // nine bits msb first, line sampled mid-high
  task automatic bits(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, d[i]);
      step(1'b1, d[i]);
      r[i] = sda_line;
      step(1'b1, d[i]);
      step(1'b0, d[i]);
    end
  endtask
  // whole bytes only; callers keep to mapped indices
  task automatic xfer(input logic [6:0] dev, input logic [7:0] idx,
    input logic rd, input logic [7:0] wd, output logic [7:0] q,
    output logic ack);
    logic [8:0] r;
    logic n;
    start();
    bits({dev, 1'b0, 1'b1}, r);
    n = r[0];
    bits({idx, 1'b1}, r);
    n = n | r[0];
    if (rd)
    begin
      start();
      bits({dev, 1'b1, 1'b1}, r);
      n = n | r[0];
      bits(9'h1FF, r);
      q = r[8:1];
    end
    else
    begin
      bits({wd, 1'b1}, r);
      n = n | r[0];
      q = 8'h00;
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    ack = !n;
  endtask
  // two-byte read: master ack after the first byte, nack after the last
  task automatic rd2(input logic [6:0] dev, input logic [7:0] idx,
    output logic [15:0] q, output logic ack);
    logic [8:0] r;
    logic n;
    start();
    bits({dev, 1'b0, 1'b1}, r);
    n = r[0];
    bits({idx, 1'b1}, r);
    n = n | r[0];
    start();
    bits({dev, 1'b1, 1'b1}, r);
    n = n | r[0];
    bits(9'h1FE, r);
    q[15:8] = r[8:1];
    bits(9'h1FF, r);
    q[7:0] = r[8:1];
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    ack = !n;
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: register-level bench of the amplifier mode control
// Assumes: host model makes every bus cycle
// Notes: outputs compared a few edges after each stop
`timescale 1ns/10ps
module tb;
  logic core_clk, rstn, pin_n, fault, scl, sda_rel, sda_out, sda_oe_n;
  logic pump, ld, rd, lf, rf, st, mo, br, a;
  logic [10:0] left_gain, right_gain;
  logic [7:0] outs, d;
  logic [15:0] q2;
  int fail_count = 0;
  int num_checks = 0;
  logic [5:0] vcode [6] = '{6'h00, 6'h01, 6'h20, 6'h34, 6'h35, 6'h3F};
  logic [10:0] vgain [6] =
    '{11'h5AD, 11'h5E9, 11'h793, 11'h7FD, 11'h001, 11'h028};
  logic [7:0] mexp [4] = '{8'hE4, 8'hE2, 8'hE1, 8'h80};
  wire sda_line = sda_rel & (sda_oe_n | sda_out);
  assign outs = {pump, ld, rd, lf, rf, st, mo, br};
  // ****************************************************************
  // instances, clock, tasks
  // ****************************************************************
  hpa_ctrl u_dut (
    .core_clk(core_clk), .rstn(rstn), .hard_power_down_n(pin_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .thermal_fault(fault),
    .charge_pump_on(pump), .left_amp_drive(ld), .right_amp_drive(rd),
    .left_output_pin_float(lf), .right_output_pin_float(rf),
    .stereo_drive(st), .mono_drive(mo), .bridge_drive(br),
    .left_gain(left_gain), .right_gain(right_gain)
  );
  hpa_host u_host (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_rel)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_host.xfer(7'h60, idx, 1'b0, v, d, a);
    chk(a, 1'b1);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    u_host.xfer(7'h60, idx, 1'b1, 8'h00, d, a);
    chk({a, d}, {1'b1, exp});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog well past the expected run
  initial
  begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    rstn = 1'b0;
    pin_n = 1'b1;
    fault = 1'b0;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({outs, left_gain}, {8'h80, 11'h418});
    rdc(8'h01, 8'h00);
    rdc(8'h02, 8'hC0);
    rdc(8'h03, 8'h00);
    // version register ignores writes and reads back as zero
    wr(8'h04, 8'hCF);
    rdc(8'h04, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h02, {2'b00, vcode[i]});
      chk({left_gain, right_gain}, {2{vgain[i]}});
    end
    wr(8'h02, 8'hBF);
    chk({left_gain, right_gain}, {11'h418, 11'h028});
    wr(8'h02, 8'h7F);
    chk({left_gain, right_gain}, {11'h028, 11'h418});
    // mode 11 written on purpose
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h01, {2'b11, m[1:0], 4'h0});
      chk(outs, mexp[m]);
    end
    wr(8'h01, 8'h80);
    chk(outs, 8'hC0);
    wr(8'h01, 8'h40);
    chk(outs, 8'hA0);
    wr(8'h01, 8'h00);
    chk(outs, 8'h80);
    // amps off and awake before floating
    wr(8'h03, 8'h02);
    chk(outs, 8'h90);
    wr(8'h03, 8'h01);
    chk(outs, 8'h88);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'hC1);
    chk(outs, 8'h00);
    rdc(8'h01, 8'h01);
    rdc(8'h02, 8'h7F);
    wr(8'h01, 8'hC0);
    chk(outs, 8'hE4);
    u_host.xfer(7'h61, 8'h01, 1'b0, 8'h00, d, a);
    chk({a, outs}, {1'b0, 8'hE4});
    pin_n = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({outs, left_gain, right_gain}, {8'h00, {2{11'h418}}});
    u_host.xfer(7'h60, 8'h01, 1'b0, 8'hC0, d, a);
    chk({a, outs}, 9'h000);
    pin_n = 1'b1;
    repeat (4) @(negedge core_clk);
    rdc(8'h01, 8'h00);
    rdc(8'h02, 8'hC0);
    chk(outs, 8'h80);
    fault = 1'b1;
    repeat (2) @(negedge core_clk);
    fault = 1'b0;
    rdc(8'h01, 8'h02);
    rdc(8'h01, 8'h00);
    // burst read: index steps from volume to float register
    u_host.rd2(7'h60, 8'h02, q2, a);
    chk({a, q2}, {1'b1, 8'hC0, 8'h00});
    report_and_stop();
  end
endmodule
